/* ssu_core.sv */
// Serial unit top: SPI master/slave engine with its flag quirks, plus UART transmit.
// Assumes control inputs come from same-clock register logic; pins are asynchronous.
//
// Functional notes
// - Transfer-active flag toggles after a transfer other than the dummy byte; data stays intact.
// - While that flag lingers, the clock request stays asserted.
// - UART transmit-complete flag sets at every byte's final stop bit.
// - Variant A wrong-idle slave: no receive, no receive flag, first bit dropped.
// - Variant B wrong-idle slave: receives fine, first byte sent twice.
// - Four-pin master: mode 0 uses enable pin as input, mode 1 drives it.
`timescale 1ns/1ps
`default_nettype none
module ssu_core
    import ssu_pkg::*;
#(
    parameter int SPI_HALF_CYC  = `SSU_SPI_HALF_CYC,
    parameter int UART_BIT_CYC  = `SSU_UART_BIT_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic       i_clk_en,
    input  wire logic       i_soft_reset,
    input  wire ssu_cfg_s   i_cfg,
    input  wire logic       i_tx_write,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_rx_read,
    input  wire logic       i_tx_complete_clear,
    input  wire logic       i_uart_write,
    input  wire logic [7:0] i_uart_data,
    input  wire logic       i_sck,
    input  wire logic       i_sdi,
    input  wire logic       i_slave_enable_pin_n,
    output logic            o_sck,
    output logic            o_sck_oe,
    output logic            o_sdo,
    output logic            o_sdo_oe,
    output logic            o_slave_enable_pin_n,
    output logic            o_slave_enable_oe,
    output logic [7:0]      o_rx_buffer_reg,
    output ssu_flags_s      o_flags,
    output logic            o_clock_request,
    output logic            o_uart_ready,
    output logic            o_uart_txd
);
    ssu_spi_state_e state_ff;
    logic [2:0]     sync_ff [0:1];
    logic           sck_d_ff;
    logic [7:0]     tx_buf_ff;
    logic           tx_full_ff;
    logic [7:0]     rx_buf_ff;
    logic           rx_rdy_ff;
    logic           txcpt_ff;
    logic [7:0]     tx_sh_ff;
    logic [7:0]     rx_sh_ff;
    logic [7:0]     cur_byte_ff;
    logic [2:0]     bit_cnt_ff;
    logic [4:0]     tog_cnt_ff;
    logic [15:0]    div_cnt_ff;
    logic           msck_ff;
    logic           sdo_ff;
    logic           busy_ff;
    logic           misidle_ff;
    logic           dup_first_ff;
    logic           soft_q_ff;
    logic           sck_oe_ff;
    logic           sdo_oe_ff;
    logic           ste_ff;
    logic           ste_oe_ff;
    logic           uart_done;

    // First bit presented at load in phase 0, at the first leading edge in phase 1; a wrong-idle variant A slave loses it.
    function automatic logic [7:0] load_shift(input logic [7:0] data, input logic drop);
        load_shift = drop ? {data[6:0], 1'b0} : data;
    endfunction

    // Two-flop synchronisers for clock, data and enable pins.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sync_ff[0] <= 3'h7;
            sync_ff[1] <= 3'h7;
            sck_d_ff   <= 1'b1;
        end else if (i_clk_en) begin
            sync_ff[0] <= {i_slave_enable_pin_n, i_sdi, i_sck};
            sync_ff[1] <= sync_ff[0];
            sck_d_ff   <= sync_ff[1][0];
        end
    end

    wire sck_s = sync_ff[1][0];
    wire sdi_s = sync_ff[1][1];
    wire ste_s = sync_ff[1][2];
    wire pol   = i_cfg.clock_polarity_sel;
    wire pha   = i_cfg.clock_phase_sel;

    // Slave select is active low; in conflict mode a high pin means master-active.
    wire conflict  = i_cfg.master && i_cfg.four_pin && !i_cfg.enable_pin_mode_sel;
    wire selected  = !i_cfg.four_pin || !ste_s;
    wire in_xfer   = (state_ff == SPI_XFER);
    wire m_tick    = in_xfer && (div_cnt_ff == 16'(SPI_HALF_CYC - 1));
    wire s_change  = in_xfer && (sck_s != sck_d_ff);
    wire lead      = i_cfg.master ? (m_tick && msck_ff == pol) : (s_change && sck_s != pol);
    wire trail     = i_cfg.master ? (m_tick && msck_ff != pol) : (s_change && sck_s == pol);
    wire shift_ev  = pha ? lead : trail;
    wire sample_ev = pha ? trail : lead;
    wire last_bit  = sample_ev && (bit_cnt_ff == 3'h7);
    wire m_end     = m_tick && (tog_cnt_ff == 5'(`SSU_SPI_TOGGLES - 1));
    wire xfer_end  = i_cfg.master ? m_end : last_bit;
    wire go        = !in_xfer && tx_full_ff && (i_cfg.master ? (!conflict || ste_s) : (selected && sck_s == pol));
    wire abort     = in_xfer && (i_cfg.master ? (conflict && !ste_s) : !selected);
    wire rx_ok     = !(misidle_ff && !i_cfg.variant_b);
    wire consume   = go && tx_full_ff && !(misidle_ff && i_cfg.variant_b && dup_first_ff);
    wire soft_fall = soft_q_ff && !i_soft_reset;
    wire [7:0] load_val = load_shift(tx_buf_ff, misidle_ff && !i_cfg.variant_b);

    // Wrong-idle detection at soft reset release.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            soft_q_ff    <= 1'b1;
            misidle_ff   <= 1'b0;
            dup_first_ff <= 1'b0;
        end else if (i_clk_en) begin
            soft_q_ff <= i_soft_reset;
            if (soft_fall) begin
                misidle_ff   <= !i_cfg.master && pha && (sck_s != pol);
                dup_first_ff <= 1'b1;
            end else if (go && tx_full_ff) begin
                dup_first_ff <= 1'b0;
            end
        end
    end

    // Transmit buffer and its empty flag; hardware set wins over software write.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            tx_buf_ff  <= `SSU_TX_BUF_RST;
            tx_full_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (consume) begin
                tx_full_ff <= 1'b0;
            end else if (i_tx_write) begin
                tx_buf_ff  <= i_tx_data;
                tx_full_ff <= 1'b1;
            end
        end
    end

    // Transfer state; the linger state mimics the unreliable active flag.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            state_ff <= SPI_IDLE;
        end else if (i_clk_en) begin
            case (state_ff)
                SPI_IDLE, SPI_LINGER: begin
                    if (go) begin
                        state_ff <= SPI_XFER;
                    end
                end
                SPI_XFER: begin
                    if (abort) begin
                        state_ff <= SPI_IDLE;
                    end else if (xfer_end) begin
                        state_ff <= (cur_byte_ff == `SSU_DUMMY_BYTE) ? SPI_IDLE : SPI_LINGER;
                    end
                end
                default: state_ff <= SPI_IDLE;
            endcase
        end
    end

    // Shift engine; transmit and receive shift independently; an abort drops the byte, variant A drops the first bit.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            tx_sh_ff    <= 8'h00;
            rx_sh_ff    <= 8'h00;
            cur_byte_ff <= 8'h00;
            bit_cnt_ff  <= 3'h0;
            sdo_ff      <= 1'b0;
        end else if (i_clk_en) begin
            if (go) begin
                tx_sh_ff    <= load_val;
                cur_byte_ff <= tx_buf_ff;
                bit_cnt_ff  <= 3'h0;
                if (!pha) begin
                    sdo_ff   <= load_val[7];
                    tx_sh_ff <= {load_val[6:0], 1'b0};
                end
            end else begin
                if (shift_ev) begin
                    sdo_ff   <= tx_sh_ff[7];
                    tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                end
                if (sample_ev) begin
                    rx_sh_ff   <= {rx_sh_ff[6:0], sdi_s};
                    bit_cnt_ff <= bit_cnt_ff + 3'h1;
                end
            end
        end
    end

    // Receive buffer and flags; hardware sets win over same-cycle clears.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            rx_buf_ff <= `SSU_RX_BUF_RST;
            rx_rdy_ff <= 1'b0;
            txcpt_ff  <= 1'b0;
        end else if (i_clk_en) begin
            if (last_bit && rx_ok) begin
                rx_buf_ff <= {rx_sh_ff[6:0], sdi_s};
                rx_rdy_ff <= 1'b1;
            end else if (i_rx_read) begin
                rx_rdy_ff <= 1'b0;
            end
            if (uart_done) begin
                txcpt_ff <= 1'b1;
            end else if (i_tx_complete_clear) begin
                txcpt_ff <= 1'b0;
            end
        end
    end

    // Master clock generator and edge counter.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            div_cnt_ff <= 16'h0000;
            tog_cnt_ff <= 5'h00;
            msck_ff    <= 1'b0;
        end else if (i_clk_en) begin
            if (!in_xfer || go) begin
                div_cnt_ff <= 16'h0000;
                tog_cnt_ff <= 5'h00;
                msck_ff    <= pol;
            end else if (m_tick) begin
                div_cnt_ff <= 16'h0000;
                tog_cnt_ff <= tog_cnt_ff + 5'h01;
                msck_ff    <= !msck_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 16'h0001;
            end
        end
    end

    // Active flag: set in a transfer, toggles while lingering. Toggling costs
    // power and reads low every other cycle, so a poll on it may mistake it for completion.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            busy_ff <= 1'b0;
        end else if (i_clk_en) begin
            busy_ff <= in_xfer || go || ((state_ff == SPI_LINGER) && !busy_ff);
        end
    end

    // Pin drivers, registered so no output glitches.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sck_oe_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
            ste_ff    <= 1'b1;
            ste_oe_ff <= 1'b0;
        end else if (i_clk_en) begin
            sck_oe_ff <= i_cfg.master && !(conflict && !ste_s) && !i_soft_reset;
            sdo_oe_ff <= i_cfg.master ? !(conflict && !ste_s) && !i_soft_reset : selected && !i_soft_reset;
            ste_oe_ff <= i_cfg.master && i_cfg.four_pin && i_cfg.enable_pin_mode_sel;
            ste_ff    <= !(in_xfer && i_cfg.master);
        end
    end

    ssu_uart_tx #(
        .BIT_CYC      (UART_BIT_CYC)
    ) u_uart_tx (
        .i_clock      (i_clock),
        .i_srst       (i_srst),
        .i_clk_en     (i_clk_en),
        .i_soft_reset (i_soft_reset),
        .i_wr         (i_uart_write),
        .i_data       (i_uart_data),
        .o_ready      (o_uart_ready),
        .o_txd        (o_uart_txd),
        .o_stop_done  (uart_done)
    );

    assign o_sck                         = msck_ff;
    assign o_sck_oe                      = sck_oe_ff;
    assign o_sdo                         = sdo_ff;
    assign o_sdo_oe                      = sdo_oe_ff;
    assign o_slave_enable_pin_n          = ste_ff;
    assign o_slave_enable_oe             = ste_oe_ff;
    assign o_rx_buffer_reg               = rx_buf_ff;
    assign o_flags.tx_buffer_empty_flag  = !tx_full_ff;
    assign o_flags.rx_char_ready_flag    = rx_rdy_ff;
    assign o_flags.tx_complete_flag      = txcpt_ff;
    assign o_flags.transfer_active_flag  = busy_ff;
    assign o_clock_request               = busy_ff || (state_ff == SPI_LINGER);
endmodule // ssu_core
`default_nettype wire

/* ssu_map.svh */
// Constants for the serial unit: widths, reset values and timing counts.
// Assumes inclusion by bare name from the package; design modules use its macros.
`ifndef SSU_MAP_SVH
`define SSU_MAP_SVH

`define SSU_CHAR_BITS      8
`define SSU_DUMMY_BYTE     8'h00
`define SSU_TX_BUF_RST     8'h00
`define SSU_RX_BUF_RST     8'h00
`define SSU_SPI_HALF_CYC   4
`define SSU_UART_BIT_CYC   16
`define SSU_SPI_TOGGLES    16

`endif

/* ssu_pkg.sv */
// Types shared by the serial unit modules.
// Assumes ssu_map.svh is on the include path.
`default_nettype none
package ssu_pkg;
    `include "ssu_map.svh"

    // Static configuration, driven by software-owned control bits.
    typedef struct packed {
        logic master;
        logic four_pin;
        logic enable_pin_mode_sel;
        logic clock_phase_sel;
        logic clock_polarity_sel;
        logic variant_b;
    } ssu_cfg_s;

    // Status flags seen by software.
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic rx_char_ready_flag;
        logic tx_complete_flag;
        logic transfer_active_flag;
    } ssu_flags_s;

    typedef enum logic [2:0] {
        SPI_IDLE   = 3'b001,
        SPI_XFER   = 3'b010,
        SPI_LINGER = 3'b100
    } ssu_spi_state_e;

    typedef enum logic [3:0] {
        UTX_IDLE  = 4'b0001,
        UTX_START = 4'b0010,
        UTX_DATA  = 4'b0100,
        UTX_STOP  = 4'b1000
    } ssu_utx_state_e;
endpackage
`default_nettype wire

/* ssu_uart_tx.sv */
// UART transmitter with one holding register, 8N1 framing, LSB first.
// Assumes a same-domain writer that only writes while o_ready is high.
`timescale 1ns/1ps
`default_nettype none
module ssu_uart_tx
    import ssu_pkg::*;
#(
    parameter int BIT_CYC = `SSU_UART_BIT_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic       i_clk_en,
    input  wire logic       i_soft_reset,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_data,
    output logic            o_ready,
    output logic            o_txd,
    output logic            o_stop_done
);
    ssu_utx_state_e state_ff;
    logic [7:0]     hold_ff;
    logic           full_ff;
    logic [7:0]     sh_ff;
    logic [2:0]     bit_ff;
    logic [15:0]    cnt_ff;
    logic           txd_ff;
    logic           done_ff;

    // One baud tick per bit time; the last stop-bit tick marks byte end.
    wire tick     = (cnt_ff == 16'(BIT_CYC - 1));
    wire byte_end = tick && (state_ff == UTX_STOP);
    wire take     = full_ff && ((state_ff == UTX_IDLE) || byte_end);

    // Holding register; a write while full is ignored by design.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            full_ff <= 1'b0;
            hold_ff <= `SSU_TX_BUF_RST;
        end else if (i_clk_en) begin
            if (i_wr && !full_ff) begin
                hold_ff <= i_data;
                full_ff <= 1'b1;
            end else if (take) begin
                full_ff <= 1'b0;
            end
        end
    end

    // Framing engine. Back-to-back bytes go straight from stop to start.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            state_ff <= UTX_IDLE;
            cnt_ff   <= 16'h0000;
            bit_ff   <= 3'h0;
            sh_ff    <= 8'h00;
            txd_ff   <= 1'b1;
            done_ff  <= 1'b0;
        end else if (i_clk_en) begin
            done_ff <= byte_end;
            cnt_ff  <= (tick || state_ff == UTX_IDLE) ? 16'h0000 : cnt_ff + 16'h0001;
            case (state_ff)
                UTX_IDLE: begin
                    if (take) begin
                        sh_ff    <= hold_ff;
                        txd_ff   <= 1'b0;
                        state_ff <= UTX_START;
                    end
                end
                UTX_START: begin
                    if (tick) begin
                        txd_ff   <= sh_ff[0];
                        sh_ff    <= {1'b0, sh_ff[7:1]};
                        bit_ff   <= 3'h0;
                        state_ff <= UTX_DATA;
                    end
                end
                UTX_DATA: begin
                    if (tick) begin
                        txd_ff <= (bit_ff == 3'h7) ? 1'b1 : sh_ff[0];
                        sh_ff  <= {1'b0, sh_ff[7:1]};
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7) begin
                            state_ff <= UTX_STOP;
                        end
                    end
                end
                UTX_STOP: begin
                    if (take) begin
                        sh_ff    <= hold_ff;
                        txd_ff   <= 1'b0;
                        state_ff <= UTX_START;
                    end else if (tick) begin
                        state_ff <= UTX_IDLE;
                    end
                end
                default: state_ff <= UTX_IDLE;
            endcase
        end
    end

    assign o_ready     = !full_ff;
    assign o_txd       = txd_ff;
    assign o_stop_done = done_ff;
endmodule // ssu_uart_tx
`default_nettype wire

/* ssu_core_assertions.sv */
// Concurrent checks on the serial unit top: pins, flags, UART timing.
// Assumes it is bound into ssu_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ssu_core_assertions
    import ssu_pkg::*;
#(
    parameter int UART_BIT_CYC = 16
) (
    input wire logic       i_clock,
    input wire logic       i_srst,
    input wire logic       i_clk_en,
    input wire logic       i_soft_reset,
    input wire ssu_cfg_s   i_cfg,
    input wire logic       i_tx_write,
    input wire logic       i_rx_read,
    input wire logic       i_tx_complete_clear,
    input wire logic       i_slave_enable_pin_n,
    input wire logic       o_sck,
    input wire logic       o_sck_oe,
    input wire logic       o_sdo_oe,
    input wire logic       o_slave_enable_oe,
    input wire ssu_flags_s o_flags,
    input wire logic       o_clock_request,
    input wire logic       o_uart_ready,
    input wire logic       o_uart_txd
);
    // Margin allows for frozen cycles beyond one frame.
    localparam int TXC_MAX = 10 * UART_BIT_CYC + 12;
    // Mode decode shared by the enable-pin properties.
    wire logic drive_en = i_cfg.master && i_cfg.four_pin && i_cfg.enable_pin_mode_sel;
    wire logic conflict = i_cfg.master && i_cfg.four_pin && !i_cfg.enable_pin_mode_sel;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    AST_RESET_VALUES: assert property ($fell(i_srst) |-> !o_sck_oe && !o_sdo_oe && !o_slave_enable_oe
        && !o_sck && o_uart_txd && o_flags == 4'h8) else $error("Bad reset outputs.");
    AST_STE_DRIVE: assert property (i_clk_en && drive_en && !i_soft_reset ##1 !i_soft_reset
        |-> o_slave_enable_oe) else $error("Enable pin not driven.");
    AST_STE_INPUT: assert property (i_clk_en && !drive_en |=> !o_slave_enable_oe)
        else $error("Enable pin driven.");
    AST_CONFLICT_HOLD: assert property ((conflict && !i_slave_enable_pin_n) [*5] |=> $stable(o_sck))
        else $error("Clock moved while disabled.");
    AST_CLKREQ_BUSY: assert property (o_flags.transfer_active_flag |-> o_clock_request)
        else $error("No clock request.");
    AST_TXC_SET: assert property ($fell(o_uart_txd) && i_clk_en |-> ##[1:TXC_MAX] o_flags.tx_complete_flag)
        else $error("No transmit complete.");
    AST_TXC_CLEAR: assert property (i_clk_en && i_tx_complete_clear && o_uart_ready && o_uart_txd
        |=> !o_flags.tx_complete_flag) else $error("Complete flag not cleared.");
    AST_RX_READ: assert property (i_clk_en && i_rx_read && !o_clock_request
        |=> !o_flags.rx_char_ready_flag) else $error("Receive flag not cleared.");
    AST_TX_LOAD: assert property (i_clk_en && i_tx_write && o_flags.tx_buffer_empty_flag && !i_soft_reset
        |=> !o_flags.tx_buffer_empty_flag) else $error("Buffer not filled.");
    AST_FREEZE: assert property (!i_clk_en |=> $stable(o_uart_txd) && $stable(o_flags))
        else $error("State moved while frozen.");

    // Main scenarios.
    COV_RX: cover property ($rose(o_flags.rx_char_ready_flag));
    COV_LINGER: cover property (o_clock_request && !o_flags.transfer_active_flag ##1 o_flags.transfer_active_flag);
    COV_TXC: cover property ($rose(o_flags.tx_complete_flag));
endmodule // ssu_core_assertions

bind ssu_core ssu_core_assertions #(.UART_BIT_CYC(UART_BIT_CYC)) u_ssu_chk (
    .i_clock(i_clock), .i_srst(i_srst), .i_clk_en(i_clk_en), .i_soft_reset(i_soft_reset), .i_cfg(i_cfg),
    .i_tx_write(i_tx_write), .i_rx_read(i_rx_read), .i_tx_complete_clear(i_tx_complete_clear),
    .i_slave_enable_pin_n(i_slave_enable_pin_n), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_sdo_oe(o_sdo_oe),
    .o_slave_enable_oe(o_slave_enable_oe), .o_flags(o_flags), .o_clock_request(o_clock_request),
    .o_uart_ready(o_uart_ready), .o_uart_txd(o_uart_txd));
`default_nettype wire

/* ssu_spi_master_model.sv */
// Behavioural external SPI master with a 160 ns bit period, MSB first.
// Assumes the bench calls its tasks; the clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module ssu_spi_master_model (
    input  wire logic i_cpol,
    input  wire logic i_cpha,
    input  wire logic i_miso,
    output logic      o_sck,
    output logic      o_mosi
);
    initial begin
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end

    // Parks the clock; a wrong level here models a careless master.
    task automatic park(input logic v);
        o_sck = v;
    endtask

    // One byte each way; the released data line shows the inverse.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        o_sck = i_cpol;
        #80;
        for (int i = 7; i >= 0; i--) begin
            if (!i_cpha) o_mosi = tx[i];
            #80 o_sck = ~i_cpol;
            if (i_cpha) o_mosi = tx[i];
            else rx[i] = i_miso;
            #80 o_sck = i_cpol;
            if (i_cpha) rx[i] = i_miso;
        end
        #80 o_mosi = ~o_mosi;
    endtask
endmodule // ssu_spi_master_model
`default_nettype wire

/* serial_spi_uart_unit_quirks_tb_top.sv */
// Self-checking bench for the serial unit: SPI master loopback, slave via model, UART.
// Assumes the package, design, checker and model compile first.
`timescale 1ns/1ps
`default_nettype none
module serial_spi_uart_unit_quirks_tb_top;
    import ssu_pkg::*;
    localparam int HALF = 4;
    localparam int BITC = 4;
    logic       i_clock = 1'b0;
    logic       srst = 1'b1, clk_en = 1'b1, soft_rst = 1'b1, ste_n = 1'b1;
    logic       tx_wr = 1'b0, rx_rd = 1'b0, txc_clr = 1'b0, u_wr = 1'b0;
    logic [7:0] tx_d = 8'h00, u_d = 8'h00, rx_buf;
    ssu_cfg_s   cfg = '0;
    ssu_flags_s flags;
    logic       m_sck, m_mosi, o_sck, o_sck_oe, o_sdo, o_sdo_oe, ste_o_n, ste_oe, clk_req, u_ready, u_txd;
    int         error_cnt = 0, num_checks = 0, seed = 32'h2016AF35;
    // Master modes loop data back; a released data line shows the inverse.
    wire logic  miso_w = o_sdo_oe ? o_sdo : ~o_sdo;
    wire logic  sck_w = cfg.master ? o_sck : m_sck;
    wire logic  sdi_w = cfg.master ? miso_w : m_mosi;

    always #10 i_clock = ~i_clock;

    ssu_core #(.SPI_HALF_CYC(HALF), .UART_BIT_CYC(BITC)) DUT (
        .i_clock(i_clock), .i_srst(srst), .i_clk_en(clk_en), .i_soft_reset(soft_rst), .i_cfg(cfg),
        .i_tx_write(tx_wr), .i_tx_data(tx_d), .i_rx_read(rx_rd), .i_tx_complete_clear(txc_clr),
        .i_uart_write(u_wr), .i_uart_data(u_d), .i_sck(sck_w), .i_sdi(sdi_w), .i_slave_enable_pin_n(ste_n),
        .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_slave_enable_pin_n(ste_o_n),
        .o_slave_enable_oe(ste_oe), .o_rx_buffer_reg(rx_buf), .o_flags(flags), .o_clock_request(clk_req),
        .o_uart_ready(u_ready), .o_uart_txd(u_txd));
    ssu_spi_master_model u_partner (.i_cpol(cfg.clock_polarity_sel), .i_cpha(cfg.clock_phase_sel),
        .i_miso(miso_w), .o_sck(m_sck), .o_mosi(m_mosi));

    // Inputs change 2 ns after the rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #2;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic pulse_tx(input logic [7:0] b);
        tx_d = b;
        tx_wr = 1'b1;
        tick(1);
        tx_wr = 1'b0;
    endtask
    task automatic read_rx();
        rx_rd = 1'b1;
        tick(1);
        rx_rd = 1'b0;
    endtask
    task automatic wait_rx();
        for (int i = 0; i < 400 && flags.rx_char_ready_flag !== 1'b1; i++) tick(1);
        chk_bit(flags.rx_char_ready_flag, 1'b1);
    endtask
    task automatic wait_txc(output int n);
        for (n = 0; n < 30 * BITC && flags.tx_complete_flag !== 1'b1; n++) tick(1);
    endtask
    // Config changes in soft reset; ok=0 parks the clock wrong.
    task automatic cfg_set(input ssu_cfg_s c, input logic ok);
        soft_rst = 1'b1;
        cfg = c;
        u_partner.park(c.clock_polarity_sel ^ !ok);
        tick(4);
        soft_rst = 1'b0;
        tick(1);
    endtask
    task automatic slave_xfer(input logic [7:0] b, input logic [7:0] r, output logic [7:0] g);
        pulse_tx(b);
        u_partner.xfer(r, g);
        tick(8);
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under 20000 cycles.
    initial begin
        #1000000;
        error_cnt++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        int n;
        logic [7:0] b, r, g;
        tick(16);
        srst = 1'b0;
        tick(1);
        // Four-pin master in output mode, every phase and polarity.
        for (int k = 0; k < 4; k++) begin
            cfg_set(ssu_cfg_s'({3'b111, 2'(k), 1'b0}), 1'b1);
            chk_bit(ste_oe, 1'b1);
            b = 8'($random(seed)) | 8'h01;
            pulse_tx(b);
            tick(2);
            chk_bit(ste_o_n, 1'b0);
            wait_rx();
            chk_byte(rx_buf, b);
            read_rx();
            tick(4 * HALF);
            chk_bit(clk_req, 1'b1);
            pulse_tx(8'h00);
            wait_rx();
            tick(4 * HALF);
            read_rx();
            chk_bit(clk_req, 1'b0);
        end
        $display("test 1 done");
        // Conflict mode: good byte, aborted byte, then rewrite.
        cfg_set(ssu_cfg_s'(6'h30), 1'b1);
        chk_bit(ste_oe, 1'b0);
        b = 8'($random(seed));
        pulse_tx(b);
        wait_rx();
        chk_byte(rx_buf, b);
        read_rx();
        pulse_tx(~b);
        tick(3 * HALF);
        ste_n = 1'b0;
        tick(20 * HALF);
        chk_bit(flags.rx_char_ready_flag, 1'b0);
        chk_bit(flags.tx_buffer_empty_flag, 1'b1);
        ste_n = 1'b1;
        tick(4);
        pulse_tx(b ^ 8'h5A);
        wait_rx();
        chk_byte(rx_buf, b ^ 8'h5A);
        read_rx();
        $display("test 2 done");
        // Slave modes behind the external master.
        for (int k = 0; k < 4; k++) begin
            cfg_set(ssu_cfg_s'({3'b000, 2'(k), 1'b0}), 1'b1);
            b = 8'($random(seed));
            r = 8'($random(seed));
            slave_xfer(b, r, g);
            chk_byte(rx_buf, r);
            chk_byte(g, b);
            read_rx();
        end
        $display("test 3 done");
        // Phase-1 slave released with the clock wrong, then recovered.
        cfg_set(ssu_cfg_s'(6'h04), 1'b0);
        slave_xfer(8'hA5, 8'h3C, g);
        chk_bit(flags.rx_char_ready_flag, 1'b0);
        chk_byte({1'b0, g[7:1]}, {1'b0, 7'h25});
        cfg_set(ssu_cfg_s'(6'h04), 1'b1);
        slave_xfer(8'hA5, 8'h3C, g);
        chk_byte(rx_buf, 8'h3C);
        read_rx();
        cfg_set(ssu_cfg_s'(6'h05), 1'b0);
        b = 8'($random(seed));
        slave_xfer(b, 8'hC3, g);
        chk_byte(rx_buf, 8'hC3);
        read_rx();
        u_partner.xfer(8'h96, g);
        tick(8);
        chk_byte(rx_buf, 8'h96);
        chk_byte(g, b);
        read_rx();
        $display("test 4 done");
        // Two UART bytes back to back; completion flags once per byte.
        u_d = 8'($random(seed));
        u_wr = 1'b1;
        tick(1);
        u_wr = 1'b0;
        for (int i = 0; i < 50 && u_ready !== 1'b1; i++) tick(1);
        u_d = ~u_d;
        u_wr = 1'b1;
        tick(1);
        u_wr = 1'b0;
        wait_txc(n);
        chk_bit(n < 11 * BITC, 1'b1);
        txc_clr = 1'b1;
        tick(1);
        txc_clr = 1'b0;
        tick(1);
        chk_bit(flags.tx_complete_flag, 1'b0);
        clk_en = 1'b0;
        tick(5);
        clk_en = 1'b1;
        wait_txc(n);
        chk_bit(flags.tx_complete_flag, 1'b1);
        tick(2 * BITC);
        txc_clr = 1'b1;
        tick(1);
        txc_clr = 1'b0;
        $display("test 5 done");
        print_verdict();
    end
endmodule // serial_spi_uart_unit_quirks_tb_top
`default_nettype wire
